// ### rtl/bcce_pkg.sv
// constants, opcodes and register offsets for the branch/call/clear core
package bcce_pkg;
  localparam int PC_W = 21;
  localparam int DADDR_W = 12;
  localparam int RADDR_W = 5;
  localparam int STKPTR_W = 5;

  // four phases per instruction cycle
  localparam logic [1:0] Q_DECODE = 2'h0;
  localparam logic [1:0] Q_READ = 2'h1;
  localparam logic [1:0] Q_PROCESS = 2'h2;
  localparam logic [1:0] Q_WRITE = 2'h3;

  // opcodes
  localparam logic [15:0] OP_NOP = 16'h0000;
  localparam logic [15:0] OP_WATCHDOG_CLEAR = 16'h0004;
  localparam logic [3:0] OP_BIT_TOGGLE = 4'h7;
  localparam logic [3:0] OP_SECOND_WORD = 4'hF;
  localparam logic [7:0] OP_BRANCH_OVERFLOW = 8'hE4;
  localparam logic [7:0] OP_BRANCH_ZERO = 8'hE0;
  localparam logic [6:0] OP_CALL = 7'h76;
  localparam logic [6:0] OP_REGISTER_CLEAR = 7'h35;

  // instruction fields
  localparam int BANK_BIT = 8;
  localparam int SAVE_BIT = 8;
  localparam int BIT_SEL_LSB = 9;

  // status bit positions
  localparam int ST_Z = 2;
  localparam int ST_OV = 3;
  localparam int ST_W = 5;

  // access bank split and offsets
  localparam logic [7:0] ACCESS_SPLIT = 8'h5F;
  localparam logic [3:0] ACCESS_LOW_BANK = 4'h0;
  localparam logic [3:0] ACCESS_HIGH_BANK = 4'hF;
  localparam logic [PC_W-1:0] PC_STEP = 21'h000002;
  localparam logic [PC_W-1:0] PC_RESET = 21'h000000;

  // register port offsets
  localparam logic [RADDR_W-1:0] R_CTRL = 5'h00;
  localparam logic [RADDR_W-1:0] R_WORK = 5'h01;
  localparam logic [RADDR_W-1:0] R_STATUS = 5'h02;
  localparam logic [RADDR_W-1:0] R_BANK = 5'h03;
  localparam logic [RADDR_W-1:0] R_FSR2L = 5'h04;
  localparam logic [RADDR_W-1:0] R_FSR2H = 5'h05;
  localparam logic [RADDR_W-1:0] R_WORK_SH = 5'h06;
  localparam logic [RADDR_W-1:0] R_STATUS_SH = 5'h07;
  localparam logic [RADDR_W-1:0] R_BANK_SH = 5'h08;
  localparam logic [RADDR_W-1:0] R_STACKL = 5'h09;
  localparam logic [RADDR_W-1:0] R_STACKH = 5'h0A;
  localparam logic [RADDR_W-1:0] R_STACKU = 5'h0B;
  localparam logic [RADDR_W-1:0] R_PCL = 5'h0C;
  localparam logic [RADDR_W-1:0] R_PCH = 5'h0D;
  localparam logic [RADDR_W-1:0] R_PCU = 5'h0E;
  localparam logic [RADDR_W-1:0] R_STKPTR = 5'h0F;
  localparam logic [RADDR_W-1:0] R_MEMADDRL = 5'h10;
  localparam logic [RADDR_W-1:0] R_MEMADDRH = 5'h11;
  localparam logic [RADDR_W-1:0] R_MEMDATA = 5'h12;
  localparam logic [RADDR_W-1:0] R_FLAGS = 5'h13;

  localparam int CTRL_RUN = 0;
  localparam int CTRL_EXT = 1;
  localparam logic [STKPTR_W-1:0] STACK_FULL = 5'h1F;

  // data address for byte and bit register instructions
  function automatic logic [DADDR_W-1:0] bcce_eff_addr(input logic [7:0] f, input logic a,
                                                       input logic ext, input logic [3:0] bank,
                                                       input logic [DADDR_W-1:0] fsr2);
    if (a) begin
      return {bank, f};
    end else if (ext && f <= ACCESS_SPLIT) begin
      return fsr2 + {4'h0, f};
    end else if (f <= ACCESS_SPLIT) begin
      return {ACCESS_LOW_BANK, f};
    end else begin
      return {ACCESS_HIGH_BANK, f};
    end
  endfunction
endpackage

// ### rtl/bcce_data_mem.sv
// banked data register file with registered read data
`timescale 1ns/100ps
module bcce_data_mem #(
  parameter int ADDR_W = 12,
  parameter int DATA_W = 8
) (
  input wire logic mclk,
  input wire logic ce,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] wdata,
  input wire logic we,
  input wire logic re,
  output logic [DATA_W-1:0] rdata
);
  logic [DATA_W-1:0] mem [2**ADDR_W];

  // no reset on the array: contents are undefined until written
  always_ff @(posedge mclk) begin
    if (ce) begin
      if (we) begin
        mem[addr] <= wdata;
      end
      if (re) begin
        rdata <= mem[addr];
      end
    end
  end
endmodule // bcce_data_mem

// ### rtl/bcce_core.sv
// execution core for toggle, branch, call and clear instructions
// Functional notes
// - bit toggle inverts bit b of the register, writes back, flags untouched.
// - upper byte E4 is branch on overflow, taken only when overflow is one.
// - upper byte E0 is branch on zero, taken only when zero is one.
// - taken branch loads incremented counter plus twice the signed offset.
// - untaken branch one cycle; taken writes counter in phase four, then a dead cycle.
// - call pushes its own address plus four onto the return stack.
// - call with save bit set copies working, status, bank select into shadows.
// - call with save bit clear leaves the shadow registers alone.
// - call target bits go to counter bits 20..1, low eight from word one.
// - call is two words, two cycles; push in phase three, counter in phase four.
// - register clear writes zero and sets the zero flag in one cycle.
// - bank bit clear uses the access bank, set uses the bank select register.
// - extended set, bank bit clear, address up to 5F uses indexed offset.
// - watchdog clear zeroes counter and postscaler, sets timeout and powerdown flags.
//
// Added by the designer: the plain strobed port and the address map.
`timescale 1ns/100ps
module bcce_core (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic ce,
  input wire logic [bcce_pkg::RADDR_W-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr_stb,
  input wire logic reg_rd_stb,
  output logic [7:0] reg_rdata,
  output logic [bcce_pkg::PC_W-1:0] prog_addr,
  input wire logic [15:0] prog_rdata,
  input wire logic wdt_timeout_evt,
  input wire logic sleep_evt,
  output logic wdt_clear,
  output logic timeout_flag,
  output logic powerdown_flag
);
  import bcce_pkg::*;

  logic [1:0] q, next_q;
  logic run, next_run;
  logic ext_en, next_ext_en;
  logic [15:0] ir, next_ir;
  logic [PC_W-1:0] pc, next_pc;
  logic [7:0] work, next_work;
  logic [ST_W-1:0] status, next_status;
  logic [3:0] bank_select_reg, next_bank_select_reg;
  logic [DADDR_W-1:0] fsr2, next_fsr2;
  logic [7:0] working_shadow, next_working_shadow;
  logic [ST_W-1:0] status_shadow, next_status_shadow;
  logic [3:0] bank_select_shadow, next_bank_select_shadow;
  logic [PC_W-1:0] stack_top, next_stack_top;
  logic [STKPTR_W-1:0] stack_ptr, next_stack_ptr;
  logic [DADDR_W-1:0] host_addr, next_host_addr;
  logic next_wdt_clear, next_timeout_flag, next_powerdown_flag;
  logic [7:0] rd_reg, next_rd_reg;
  logic sel_mem, next_sel_mem;
  logic [DADDR_W-1:0] mem_addr;
  logic [7:0] mem_wdata, mem_rdata;
  logic mem_we, mem_re;

  logic is_btg, is_bov, is_bz, is_call, is_register_clear_op, is_watchdog_clear_op, is_prefix, taken;
  logic [DADDR_W-1:0] eff_addr;
  logic [PC_W-1:0] branch_target;

  // decode of the word in the instruction register
  always_comb begin
    is_btg = ir[15:12] == OP_BIT_TOGGLE;
    is_bov = ir[15:8] == OP_BRANCH_OVERFLOW;
    is_bz = ir[15:8] == OP_BRANCH_ZERO;
    is_call = ir[15:9] == OP_CALL;
    is_register_clear_op = ir[15:9] == OP_REGISTER_CLEAR;
    is_watchdog_clear_op = ir == OP_WATCHDOG_CLEAR;
    is_prefix = ir[15:12] == OP_SECOND_WORD;
    taken = (is_bov && status[ST_OV]) || (is_bz && status[ST_Z]);
    // pc already points past the branch word
    branch_target = pc + {{(PC_W-9){ir[7]}}, ir[7:0], 1'b0};
    eff_addr = bcce_eff_addr(ir[7:0], ir[BANK_BIT], ext_en, bank_select_reg, fsr2);
  end

  always_comb begin
    next_q = q;
    next_run = run;
    next_ext_en = ext_en;
    next_ir = ir;
    next_pc = pc;
    next_work = work;
    next_status = status;
    next_bank_select_reg = bank_select_reg;
    next_fsr2 = fsr2;
    next_working_shadow = working_shadow;
    next_status_shadow = status_shadow;
    next_bank_select_shadow = bank_select_shadow;
    next_stack_top = stack_top;
    next_stack_ptr = stack_ptr;
    next_host_addr = host_addr;
    next_wdt_clear = 1'b0;
    next_timeout_flag = timeout_flag;
    next_powerdown_flag = powerdown_flag;
    mem_addr = run ? eff_addr : host_addr;
    mem_wdata = 8'h00;
    mem_we = 1'b0;
    mem_re = 1'b0;
    // hardware clears; the core's set below overrides them
    if (wdt_timeout_evt) begin
      next_timeout_flag = 1'b0;
    end
    if (sleep_evt) begin
      next_powerdown_flag = 1'b0;
    end
    if (reg_wr_stb) begin
      unique case (reg_addr)
        R_CTRL: begin
          next_run = reg_wdata[CTRL_RUN];
          next_ext_en = reg_wdata[CTRL_EXT];
        end
        R_WORK: next_work = reg_wdata;
        R_STATUS: next_status = reg_wdata[ST_W-1:0];
        R_BANK: next_bank_select_reg = reg_wdata[3:0];
        R_FSR2L: next_fsr2[7:0] = reg_wdata;
        R_FSR2H: next_fsr2[DADDR_W-1:8] = reg_wdata[3:0];
        R_WORK_SH: next_working_shadow = reg_wdata;
        R_STATUS_SH: next_status_shadow = reg_wdata[ST_W-1:0];
        R_BANK_SH: next_bank_select_shadow = reg_wdata[3:0];
        R_MEMADDRL: next_host_addr[7:0] = reg_wdata;
        R_MEMADDRH: next_host_addr[DADDR_W-1:8] = reg_wdata[3:0];
        default: begin
        end
      endcase
      // counter and data memory belong to software only while halted
      if (!run) begin
        unique case (reg_addr)
          R_PCL: next_pc[7:0] = {reg_wdata[7:1], 1'b0};
          R_PCH: next_pc[15:8] = reg_wdata;
          R_PCU: next_pc[PC_W-1:16] = reg_wdata[4:0];
          R_MEMDATA: begin
            mem_we = 1'b1;
            mem_wdata = reg_wdata;
          end
          default: begin
          end
        endcase
        // a stale prefetch must not run after a counter rewrite
        if (reg_addr == R_PCL || reg_addr == R_PCH || reg_addr == R_PCU) begin
          next_ir = OP_NOP;
        end
      end
    end
    if (reg_rd_stb && !run && reg_addr == R_MEMDATA) begin
      mem_re = 1'b1;
    end
    if (run) begin
      next_q = q + 2'h1;
      unique case (q)
        Q_DECODE: begin
          mem_re = is_btg;
        end
        Q_READ: begin
        end
        Q_PROCESS: begin
          if (is_call) begin
            next_stack_top = pc + PC_STEP;
            if (stack_ptr != STACK_FULL) begin
              next_stack_ptr = stack_ptr + 5'h01;
            end
            if (ir[SAVE_BIT]) begin
              next_working_shadow = work;
              next_status_shadow = status;
              next_bank_select_shadow = bank_select_reg;
            end
          end
          if (is_watchdog_clear_op) begin
            next_wdt_clear = 1'b1;
            next_timeout_flag = 1'b1;
            next_powerdown_flag = 1'b1;
          end
        end
        Q_WRITE: begin
          if (is_btg) begin
            mem_we = 1'b1;
            mem_wdata = mem_rdata ^ (8'h01 << ir[BIT_SEL_LSB+2:BIT_SEL_LSB]);
          end
          if (is_register_clear_op) begin
            mem_we = 1'b1;
            next_status[ST_Z] = 1'b1;
          end
          if (taken) begin
            next_pc = branch_target;
            next_ir = OP_NOP;
          end else if (is_call) begin
            // second word arrives now; its prefix is never executed
            next_pc = {prog_rdata[11:0], ir[7:0], 1'b0};
            next_ir = OP_NOP;
          end else begin
            // a lone prefix word falls through here with no effect
            next_ir = prog_rdata;
            next_pc = pc + PC_STEP;
          end
        end
      endcase
    end else begin
      next_q = Q_DECODE;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      q <= Q_DECODE;
      run <= 1'b0;
      ext_en <= 1'b0;
      ir <= OP_NOP;
      pc <= PC_RESET;
      work <= 8'h00;
      status <= 5'h00;
      bank_select_reg <= 4'h0;
      fsr2 <= 12'h000;
      working_shadow <= 8'h00;
      status_shadow <= 5'h00;
      bank_select_shadow <= 4'h0;
      stack_top <= PC_RESET;
      stack_ptr <= 5'h00;
      host_addr <= 12'h000;
      wdt_clear <= 1'b0;
      timeout_flag <= 1'b1;
      powerdown_flag <= 1'b1;
    end else if (ce) begin
      q <= next_q;
      run <= next_run;
      ext_en <= next_ext_en;
      ir <= next_ir;
      pc <= next_pc;
      work <= next_work;
      status <= next_status;
      bank_select_reg <= next_bank_select_reg;
      fsr2 <= next_fsr2;
      working_shadow <= next_working_shadow;
      status_shadow <= next_status_shadow;
      bank_select_shadow <= next_bank_select_shadow;
      stack_top <= next_stack_top;
      stack_ptr <= next_stack_ptr;
      host_addr <= next_host_addr;
      wdt_clear <= next_wdt_clear;
      timeout_flag <= next_timeout_flag;
      powerdown_flag <= next_powerdown_flag;
    end
  end
  assign prog_addr = pc;
  // register port read side
  always_comb begin
    next_sel_mem = reg_rd_stb && reg_addr == R_MEMDATA && !run;
    next_rd_reg = 8'h00;
    if (reg_rd_stb) begin
      unique case (reg_addr)
        R_CTRL: next_rd_reg = {6'h00, ext_en, run};
        R_WORK: next_rd_reg = work;
        R_STATUS: next_rd_reg = {3'h0, status};
        R_BANK: next_rd_reg = {4'h0, bank_select_reg};
        R_FSR2L: next_rd_reg = fsr2[7:0];
        R_FSR2H: next_rd_reg = {4'h0, fsr2[DADDR_W-1:8]};
        R_WORK_SH: next_rd_reg = working_shadow;
        R_STATUS_SH: next_rd_reg = {3'h0, status_shadow};
        R_BANK_SH: next_rd_reg = {4'h0, bank_select_shadow};
        R_STACKL: next_rd_reg = stack_top[7:0];
        R_STACKH: next_rd_reg = stack_top[15:8];
        R_STACKU: next_rd_reg = {3'h0, stack_top[PC_W-1:16]};
        R_PCL: next_rd_reg = pc[7:0];
        R_PCH: next_rd_reg = pc[15:8];
        R_PCU: next_rd_reg = {3'h0, pc[PC_W-1:16]};
        R_STKPTR: next_rd_reg = {3'h0, stack_ptr};
        R_MEMADDRL: next_rd_reg = host_addr[7:0];
        R_MEMADDRH: next_rd_reg = {4'h0, host_addr[DADDR_W-1:8]};
        R_FLAGS: next_rd_reg = {6'h00, powerdown_flag, timeout_flag};
        default: next_rd_reg = 8'h00;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      rd_reg <= 8'h00;
      sel_mem <= 1'b0;
    end else if (ce) begin
      rd_reg <= next_rd_reg;
      sel_mem <= next_sel_mem;
    end
  end

  assign reg_rdata = sel_mem ? mem_rdata : rd_reg;

  bcce_data_mem #(.ADDR_W(DADDR_W), .DATA_W(8)) u_data_mem (
    .mclk(mclk),
    .ce(ce),
    .addr(mem_addr),
    .wdata(mem_wdata),
    .we(mem_we),
    .re(mem_re),
    .rdata(mem_rdata)
  );

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn || !ce);

  a_btg_write: assert property (run && q == Q_WRITE && is_btg && !reg_wr_stb |->
    mem_we && mem_wdata == (mem_rdata ^ (8'h01 << ir[11:9])) ##1 status == $past(status))
    else $error("toggle result or flags wrong");
  a_bov_taken: assert property (run && q == Q_WRITE && is_bov && status[ST_OV] |=>
    pc == $past(pc) + {{12{$past(ir[7])}}, $past(ir[7:0]), 1'b0} && ir == OP_NOP)
    else $error("overflow branch target wrong");
  a_bz_skip: assert property (run && q == Q_WRITE && is_bz && !status[ST_Z] |=>
    pc == $past(pc) + PC_STEP && ir == $past(prog_rdata))
    else $error("untaken zero branch did not fall through");
  a_branch_dead: assert property (run && q == Q_WRITE && taken |=> ir == OP_NOP [*4])
    else $error("taken branch missing dead cycle");
  a_branch_phase: assert property (run && q != Q_WRITE && (is_bz || is_bov) && !reg_wr_stb |=> $stable(pc))
    else $error("branch wrote counter outside phase four");
  a_call_push: assert property (run && q == Q_PROCESS && is_call |=> stack_top == $past(pc) + PC_STEP)
    else $error("return address wrong");
  a_call_save: assert property (run && q == Q_PROCESS && is_call && ir[8] |=>
    working_shadow == $past(work) && status_shadow == $past(status)
    && bank_select_shadow == $past(bank_select_reg))
    else $error("shadow copy missing");
  a_call_nosave: assert property (run && q == Q_PROCESS && is_call && !ir[8] && !reg_wr_stb |=>
    $stable(working_shadow) && $stable(status_shadow) && $stable(bank_select_shadow))
    else $error("shadow changed without save bit");
  a_call_target: assert property (run && q == Q_WRITE && is_call |=>
    pc == {$past(prog_rdata[11:0]), $past(ir[7:0]), 1'b0} ##4 ir == $past(prog_rdata))
    else $error("call target wrong");
  // push lands at the phase-three edge, counter only at the phase-four edge
  a_call_cycles: assert property (run && q == Q_DECODE && is_call |-> ##2 $stable(stack_top)
    ##1 $stable(pc) && stack_top == pc + PC_STEP ##1 $changed(pc))
    else $error("call phase order wrong");
  a_register_clear_op_zero: assert property (run && q == Q_WRITE && is_register_clear_op |-> mem_we && mem_wdata == 8'h00 ##1 status[ST_Z])
    else $error("clear did not zero register or set zero flag");
  a_bank_addr: assert property (run && is_btg && ir[8] |-> mem_addr == {bank_select_reg, ir[7:0]})
    else $error("banked address wrong");
  a_index_addr: assert property (run && (is_btg || is_register_clear_op) && !ir[8] && ext_en && ir[7:0] <= ACCESS_SPLIT |->
    mem_addr == fsr2 + {4'h0, ir[7:0]})
    else $error("indexed offset address wrong");
  a_wdt_clear: assert property (run && q == Q_PROCESS && is_watchdog_clear_op |=>
    wdt_clear && timeout_flag && powerdown_flag ##1 !wdt_clear)
    else $error("watchdog clear effects wrong");
  a_lone_prefix: assert property (run && q == Q_WRITE && is_prefix && !reg_wr_stb |=>
    pc == $past(pc) + PC_STEP && status == $past(status) && !wdt_clear)
    else $error("lone prefix word had an effect");
endmodule // bcce_core

// ### sim/bcce_prog_model.sv
// program memory model that answers fetches promptly or late
`timescale 1ns/100ps
module bcce_prog_model (
  input wire logic mclk,
  input wire logic slow,
  input wire logic [bcce_pkg::PC_W-1:0] prog_addr,
  output logic [15:0] prog_rdata
);
  import bcce_pkg::*;
  logic [15:0] mem [0:511];
  logic [PC_W-1:0] last_addr;
  logic [1:0] age;
  logic stale;

  // erased words read as lone second-word prefixes
  initial begin
    for (int i = 0; i < 512; i++) begin
      mem[i] = 16'hFFFF;
    end
  end

  always @(posedge mclk) begin
    last_addr <= prog_addr;
    if (prog_addr != last_addr) begin
      age <= 2'h0;
    end else if (age != 2'h3) begin
      age <= age + 2'h1;
    end
  end

  // slow mode shows wrong data for two cycles after an address change;
  // the core only samples near the end of the fetch cycle
  assign stale = slow && ((prog_addr != last_addr) || (age == 2'h0));
  assign prog_rdata = stale ? ~mem[prog_addr[9:1]] : mem[prog_addr[9:1]];
endmodule // bcce_prog_model

// ### sim/tb_top.sv
// self-checking testbench for the branch, call and clear core
`timescale 1ns/100ps
module tb_top;
  import bcce_pkg::*;
  logic mclk = 1'b0;
  logic rstn = 1'b0;
  logic [RADDR_W-1:0] reg_addr = 5'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr_stb = 1'b0;
  logic reg_rd_stb = 1'b0;
  logic [7:0] reg_rdata;
  logic [PC_W-1:0] prog_addr;
  logic [15:0] prog_rdata;
  logic wdt_timeout_evt = 1'b0;
  logic sleep_evt = 1'b0;
  logic wdt_clear;
  logic timeout_flag;
  logic powerdown_flag;
  logic slow = 1'b0;
  int fail_count = 0;
  int tests_run = 0;
  int clr_pulses = 0;
  logic [31:0] rnd = 32'h78B392B6;
  logic [7:0] rv [0:5];
  logic [2:0] bsel;

  always #4 mclk = ~mclk;
  always @(posedge mclk) if (wdt_clear === 1'b1) clr_pulses <= clr_pulses + 1;

  bcce_core dut (.mclk(mclk), .rstn(rstn), .ce(1'b1), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr_stb(reg_wr_stb), .reg_rd_stb(reg_rd_stb), .reg_rdata(reg_rdata), .prog_addr(prog_addr),
    .prog_rdata(prog_rdata), .wdt_timeout_evt(wdt_timeout_evt), .sleep_evt(sleep_evt),
    .wdt_clear(wdt_clear), .timeout_flag(timeout_flag), .powerdown_flag(powerdown_flag));

  bcce_prog_model pm (.mclk(mclk), .slow(slow), .prog_addr(prog_addr), .prog_rdata(prog_rdata));

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  function automatic logic [7:0] toggled(input logic [7:0] v, input logic [2:0] b);
    return v ^ (8'h01 << b);
  endfunction

  task automatic summarize;
    $display("checks %0d, mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic reg_wr(input logic [RADDR_W-1:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr_stb <= 1'b1;
    @(posedge mclk);
    reg_wr_stb <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic expect_reg(input logic [RADDR_W-1:0] a, input logic [7:0] exp);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd_stb <= 1'b1;
    @(posedge mclk);
    reg_rd_stb <= 1'b0;
    #1;
    chk(reg_rdata, exp);
  endtask

  task automatic mem_wr(input logic [11:0] a, input logic [7:0] d);
    reg_wr(R_MEMADDRL, a[7:0]);
    reg_wr(R_MEMADDRH, {4'h0, a[11:8]});
    reg_wr(R_MEMDATA, d);
  endtask

  task automatic expect_mem(input logic [11:0] a, input logic [7:0] exp);
    reg_wr(R_MEMADDRL, a[7:0]);
    reg_wr(R_MEMADDRH, {4'h0, a[11:8]});
    expect_reg(R_MEMDATA, exp);
  endtask

  task automatic put(input logic [PC_W-1:0] a, input logic [15:0] w);
    pm.mem[a[9:1]] = w;
  endtask

  // the core cannot stop itself, so each program ends in a tight loop
  task automatic run_for(input logic [7:0] ctrl, input int n);
    reg_wr(R_CTRL, ctrl);
    repeat (n) @(posedge mclk);
    reg_wr(R_CTRL, 8'h00);
  endtask

  initial begin
    repeat (5000) @(posedge mclk);
    fail_count++;
    $display("mismatch at %0t: watchdog expired", $time);
    summarize();
  end

  initial begin
    for (int i = 0; i < 6; i++) begin
      rnd = lfsr(rnd);
      rv[i] = rnd[7:0];
    end
    bsel = rnd[10:8];
    repeat (20) @(posedge mclk);
    rstn <= 1'b1;
    @(posedge mclk);
    #1;
    chk(prog_addr[7:0], 8'h00);
    chk({5'h00, timeout_flag, powerdown_flag, wdt_clear}, 8'h06);
    // first program: clear, zero branch, toggle, overflow branch, watchdog clear, far call with save
    put(21'h000000, 16'h6A20);
    put(21'h000002, 16'hE001);
    put(21'h000004, 16'h7120);
    put(21'h000006, {4'h7, bsel, 1'b1, 8'h21});
    put(21'h000008, 16'hE402);
    put(21'h00000A, OP_WATCHDOG_CLEAR);
    put(21'h00000C, 16'hF0AA);
    put(21'h00000E, 16'h6A80);
    put(21'h000010, 16'hED40);
    put(21'h000012, 16'hF123);
    put(21'h024680, 16'h6A22);
    put(21'h024682, 16'hE0FF);
    mem_wr(12'h020, rv[0]);
    mem_wr(12'h221, rv[1]);
    mem_wr(12'h022, rv[2]);
    mem_wr(12'hF80, rv[3]);
    reg_wr(R_WORK, rv[4]);
    reg_wr(R_STATUS, 8'h00);
    reg_wr(R_BANK, 8'h02);
    @(posedge mclk);
    wdt_timeout_evt <= 1'b1;
    @(posedge mclk);
    wdt_timeout_evt <= 1'b0;
    sleep_evt <= 1'b1;
    @(posedge mclk);
    sleep_evt <= 1'b0;
    expect_reg(R_FLAGS, 8'h00);
    run_for(8'h01, 200);
    expect_reg(R_STATUS, 8'h04);
    expect_mem(12'h020, 8'h00);
    expect_mem(12'h221, toggled(rv[1], bsel));
    expect_mem(12'hF80, 8'h00);
    expect_mem(12'h022, 8'h00);
    expect_reg(R_FLAGS, 8'h03);
    chk(8'(clr_pulses), 8'h01);
    expect_reg(R_WORK_SH, rv[4]);
    expect_reg(R_STATUS_SH, 8'h04);
    expect_reg(R_BANK_SH, 8'h02);
    expect_reg(R_STACKL, 8'h14);
    expect_reg(R_STACKH, 8'h00);
    expect_reg(R_STACKU, 8'h00);
    expect_reg(R_PCU, 8'h02);
    expect_reg(R_PCH, 8'h46);
    // second program: taken overflow branch, indexed clear, call without save, late fetch answers
    @(posedge mclk);
    rstn <= 1'b0;
    repeat (3) @(posedge mclk);
    rstn <= 1'b1;
    put(21'h0000FE, 16'hE07F);
    put(21'h000100, 16'hE401);
    put(21'h000102, 16'h6B30);
    put(21'h000104, 16'h6A10);
    put(21'h000106, 16'hEC90);
    put(21'h000108, 16'hF000);
    put(21'h000120, 16'hE0FF);
    mem_wr(12'h330, rv[0]);
    mem_wr(12'h310, rv[2]);
    mem_wr(12'h010, rv[3]);
    reg_wr(R_WORK_SH, 8'hA5);
    reg_wr(R_STATUS_SH, 8'h11);
    reg_wr(R_BANK_SH, 8'h05);
    reg_wr(R_WORK, rv[5]);
    reg_wr(R_STATUS, 8'h08);
    reg_wr(R_BANK, 8'h03);
    reg_wr(R_FSR2L, 8'h00);
    reg_wr(R_FSR2H, 8'h03);
    reg_wr(R_PCL, 8'hFE);
    slow <= 1'b1;
    run_for(8'h03, 200);
    expect_mem(12'h330, rv[0]);
    expect_mem(12'h310, 8'h00);
    expect_mem(12'h010, rv[3]);
    expect_reg(R_STATUS, 8'h0C);
    expect_reg(R_WORK_SH, 8'hA5);
    expect_reg(R_STATUS_SH, 8'h11);
    expect_reg(R_BANK_SH, 8'h05);
    expect_reg(R_STACKL, 8'h0A);
    expect_reg(R_STACKH, 8'h01);
    expect_reg(R_PCH, 8'h01);
    expect_reg(R_PCU, 8'h00);
    chk(8'(clr_pulses), 8'h01);
    summarize();
  end
endmodule // tb_top
